// ==== rtl/cal_pkg.sv ====
// constants for the calibration access and range code register bank
package cal_pkg;
  // host register offsets
  localparam logic [3:0] OFS_PAGE = 4'h8;
  localparam logic [3:0] OFS_ANALOG_CFG = 4'hB;
  localparam logic [3:0] OFS_CAL_DATA = 4'hC;
  localparam logic [3:0] OFS_CAL_ADDR = 4'hD;
  localparam logic [3:0] OFS_CAL_CTRL = 4'hE;
  localparam logic [3:0] OFS_KEY_REV = 4'hF;
  // page selection
  localparam logic [1:0] PAGE_CAL = 2'h3;
  localparam int PAGE_LSB = 0;
  localparam logic [1:0] PAGE_RESET = 2'h0;
  // eeprom unlock key
  localparam logic [7:0] EEPROM_KEY = 8'hA5;
  // calibration control write bits
  localparam int CTRL_EE_GO = 7;
  localparam int CTRL_EE_DIR = 6;
  localparam int CTRL_RUNCAL = 5;
  localparam int CTRL_CMUX = 4;
  localparam int CTRL_TRIM_GO = 3;
  // calibration status read bits
  localparam int STAT_TRIM_BUSY = 6;
  localparam int STAT_EE_BUSY = 5;
  localparam int STAT_CMUX = 4;
  localparam int STAT_TRIM_EN = 3;
  // analog configuration fields
  localparam int CFG_CODE_LSB = 0;
  localparam int CFG_SCAN_LSB = 4;
  localparam logic [3:0] CFG_CODE_RESET = 4'h0;
  localparam logic [1:0] CFG_SCAN_RESET = 2'h0;
  // range code fields
  localparam int CODE_GAIN_LSB = 0;
  localparam int CODE_POLARITY = 2;
  localparam int CODE_RANGE = 3;
  // sample width and signed full-scale limits
  localparam int SAMPLE_W = 16;
  localparam logic [15:0] SAMPLE_MIN = 16'h8000;
  localparam logic [15:0] SAMPLE_MAX = 16'h7FFF;
  // eeprom address width
  localparam int CAL_ADDR_W = 7;
endpackage

// ==== rtl/cal_range_decode.sv ====
// range code decoder: polarity, span and gain of the analog front end
`timescale 1ns/10ps
module cal_range_decode (
  // range code
  input wire logic [3:0] range_code,
  // decoded front-end settings
  output logic input_polarity_select,
  output logic range_10v,
  output logic [1:0] input_gain_select,
  output logic code_valid,
  output logic [1:0] fs_class
);
  always_comb begin
    input_polarity_select = range_code[cal_pkg::CODE_POLARITY];
    range_10v = range_code[cal_pkg::CODE_RANGE];
    input_gain_select = range_code[cal_pkg::CODE_GAIN_LSB +: 2];
    code_valid = range_10v | ~input_polarity_select;
    // span class: 5 V bipolar equals 10 V bipolar one gain step up
    // 0: +-10V family, 1: +-5V family, 2: 0-10V family
    if (input_polarity_select) begin
      fs_class = 2'h2;
    end else if (range_10v) begin
      fs_class = 2'h0;
    end else begin
      fs_class = 2'h1;
    end
  end
endmodule

// ==== rtl/cal_regs.sv ====
// calibration access, revision readback and input range code register bank
`timescale 1ns/10ps
module cal_regs #(
  parameter logic [7:0] REVISION_CODE = 8'h01 // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // host byte bus
  input wire logic [3:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // eeprom transfer engine
  output logic eeprom_transfer_go,
  output logic eeprom_direction_select,
  input wire logic eeprom_done,
  input wire logic [7:0] eeprom_read_data,
  // trim converter transfer engine
  output logic trim_transfer_go,
  input wire logic trim_done,
  // shared transfer address and data
  output logic [6:0] cal_addr,
  output logic [7:0] cal_data,
  // calibration reload and mux
  output logic reload_cal_go,
  output logic cal_mux_enable,
  // analog front end
  output logic input_polarity_select,
  output logic range_10v,
  output logic [1:0] input_gain_select,
  output logic range_code_valid,
  output logic [1:0] scan_interval,
  output logic unipolar_offset_en,
  // conversion result path
  input wire logic adc_valid,
  input wire logic [15:0] adc_code,
  output logic result_valid,
  output logic signed [15:0] result_code
);
  // ==========================================================
  // access decode
  logic [1:0] page_r, page_nxt;
  logic cal_page;
  logic wr_page;
  logic wr_cfg;
  logic wr_data;
  logic wr_addr;
  logic wr_ctrl;
  logic wr_key;

  assign cal_page = (page_r == cal_pkg::PAGE_CAL);
  assign wr_page = host_wr && (host_addr == cal_pkg::OFS_PAGE);
  assign wr_cfg = host_wr && (host_addr == cal_pkg::OFS_ANALOG_CFG);
  assign wr_data = host_wr && cal_page && (host_addr == cal_pkg::OFS_CAL_DATA);
  assign wr_addr = host_wr && cal_page && (host_addr == cal_pkg::OFS_CAL_ADDR);
  assign wr_ctrl = host_wr && cal_page && (host_addr == cal_pkg::OFS_CAL_CTRL);
  assign wr_key = host_wr && cal_page && (host_addr == cal_pkg::OFS_KEY_REV);

  // ==========================================================
  // register state
  logic [3:0] code_r, code_nxt;
  logic [1:0] scan_r, scan_nxt;
  logic [7:0] data_r, data_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic cmux_r, cmux_nxt;
  logic trim_en_r, trim_en_nxt;
  logic ee_dir_r, ee_dir_nxt;
  logic unlock_r, unlock_nxt;
  logic trim_busy_r, trim_busy_nxt;
  logic ee_busy_r, ee_busy_nxt;
  logic ee_go_r, ee_go_nxt;
  logic trim_go_r, trim_go_nxt;
  logic reload_r, reload_nxt;
  logic ee_start;
  logic trim_start;

  // eeprom go starts only when unlocked and idle
  assign ee_start = wr_ctrl && host_wdata[cal_pkg::CTRL_EE_GO] && unlock_r && !ee_busy_r;
  assign trim_start = wr_ctrl && host_wdata[cal_pkg::CTRL_TRIM_GO] && !trim_busy_r;

  always_comb begin
    page_nxt = page_r;
    code_nxt = code_r;
    scan_nxt = scan_r;
    data_nxt = data_r;
    addr_nxt = addr_r;
    cmux_nxt = cmux_r;
    trim_en_nxt = trim_en_r;
    ee_dir_nxt = ee_dir_r;
    unlock_nxt = unlock_r;
    trim_busy_nxt = trim_busy_r;
    ee_busy_nxt = ee_busy_r;
    ee_go_nxt = ee_start;
    trim_go_nxt = trim_start;
    reload_nxt = wr_ctrl && host_wdata[cal_pkg::CTRL_RUNCAL];
    if (wr_page) begin
      page_nxt = host_wdata[cal_pkg::PAGE_LSB +: 2];
    end
    if (wr_cfg) begin
      code_nxt = host_wdata[cal_pkg::CFG_CODE_LSB +: 4];
      scan_nxt = host_wdata[cal_pkg::CFG_SCAN_LSB +: 2];
    end
    if (wr_data) begin
      data_nxt = host_wdata;
    end
    if (wr_addr) begin
      addr_nxt = host_wdata[6:0];
    end
    if (wr_ctrl) begin
      cmux_nxt = host_wdata[cal_pkg::CTRL_CMUX];
      trim_en_nxt = host_wdata[cal_pkg::CTRL_TRIM_GO];
    end
    if (ee_start) begin
      ee_dir_nxt = host_wdata[cal_pkg::CTRL_EE_DIR];
    end
    if (wr_key) begin
      unlock_nxt = (host_wdata == cal_pkg::EEPROM_KEY);
    end
    if (wr_page) begin
      unlock_nxt = 1'b0;
    end
    // trim busy, start wins over done
    if (trim_done) begin
      trim_busy_nxt = 1'b0;
    end
    if (trim_start) begin
      trim_busy_nxt = 1'b1;
    end
    // eeprom busy, start wins over done
    if (ee_busy_r && eeprom_done) begin
      ee_busy_nxt = 1'b0;
      if (ee_dir_r) begin
        data_nxt = eeprom_read_data;
      end
    end
    if (ee_start) begin
      ee_busy_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      page_r <= cal_pkg::PAGE_RESET;
      code_r <= cal_pkg::CFG_CODE_RESET;
      scan_r <= cal_pkg::CFG_SCAN_RESET;
      data_r <= 8'h00;
      addr_r <= 7'h00;
      cmux_r <= 1'b0;
      trim_en_r <= 1'b0;
      ee_dir_r <= 1'b0;
      unlock_r <= 1'b0;
      trim_busy_r <= 1'b0;
      ee_busy_r <= 1'b0;
      ee_go_r <= 1'b0;
      trim_go_r <= 1'b0;
      reload_r <= 1'b0;
    end else begin
      page_r <= page_nxt;
      code_r <= code_nxt;
      scan_r <= scan_nxt;
      data_r <= data_nxt;
      addr_r <= addr_nxt;
      cmux_r <= cmux_nxt;
      trim_en_r <= trim_en_nxt;
      ee_dir_r <= ee_dir_nxt;
      unlock_r <= unlock_nxt;
      trim_busy_r <= trim_busy_nxt;
      ee_busy_r <= ee_busy_nxt;
      ee_go_r <= ee_go_nxt;
      trim_go_r <= trim_go_nxt;
      reload_r <= reload_nxt;
    end
  end

  // ==========================================================
  // host read data
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    if (host_rd) begin
      rdata_nxt = 8'h00;
      unique case (host_addr)
        cal_pkg::OFS_PAGE: begin
          rdata_nxt[cal_pkg::PAGE_LSB +: 2] = page_r;
        end
        cal_pkg::OFS_ANALOG_CFG: begin
          rdata_nxt[cal_pkg::CFG_CODE_LSB +: 4] = code_r;
        end
        cal_pkg::OFS_CAL_DATA: begin
          if (cal_page) begin
            rdata_nxt = data_r;
          end
        end
        cal_pkg::OFS_CAL_ADDR: begin
          if (cal_page) begin
            rdata_nxt = {1'b0, addr_r};
          end
        end
        cal_pkg::OFS_CAL_CTRL: begin
          if (cal_page) begin
            rdata_nxt[cal_pkg::STAT_TRIM_BUSY] = trim_busy_r;
            rdata_nxt[cal_pkg::STAT_EE_BUSY] = ee_busy_r;
            rdata_nxt[cal_pkg::STAT_CMUX] = cmux_r;
            rdata_nxt[cal_pkg::STAT_TRIM_EN] = trim_en_r;
          end
        end
        // revision on read, key on write
        cal_pkg::OFS_KEY_REV: begin
          if (cal_page) begin
            rdata_nxt = REVISION_CODE;
          end
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // range decode and conversion result
  logic [1:0] fs_class;
  logic res_valid_r, res_valid_nxt;
  logic [15:0] res_r, res_nxt;

  cal_range_decode u_decode (
    .range_code(code_r),
    .input_polarity_select(input_polarity_select),
    .range_10v(range_10v),
    .input_gain_select(input_gain_select),
    .code_valid(range_code_valid),
    .fs_class(fs_class)
  );

  always_comb begin
    res_valid_nxt = adc_valid;
    res_nxt = res_r;
    if (adc_valid) begin
      res_nxt = adc_code;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      res_valid_r <= 1'b0;
      res_r <= 16'h0000;
    end else begin
      res_valid_r <= res_valid_nxt;
      res_r <= res_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign host_rdata = rdata_r;
  assign eeprom_transfer_go = ee_go_r;
  assign eeprom_direction_select = ee_dir_r;
  assign trim_transfer_go = trim_go_r;
  assign cal_addr = addr_r;
  assign cal_data = data_r;
  assign reload_cal_go = reload_r;
  assign cal_mux_enable = cmux_r;
  assign scan_interval = scan_r;
  // front end shifts unipolar input by half scale
  assign unipolar_offset_en = (fs_class == 2'h2);
  assign result_valid = res_valid_r;
  assign result_code = res_r;
endmodule

// ==== sim/cal_engine_model.sv ====
// behavioural eeprom and trim transfer engines
`timescale 1ns/10ps
module cal_engine_model #(
  parameter int DLY = 6,
  parameter logic [7:0] RD = 8'h3C
) (
  // clock
  input wire logic sys_clk,
  // starts from the bank
  input wire logic eeprom_transfer_go,
  input wire logic eeprom_direction_select,
  input wire logic trim_transfer_go,
  // completions
  output logic eeprom_done = 1'b0,
  output logic [7:0] eeprom_read_data,
  output logic trim_done = 1'b0
);
  int ee_n = 0;
  int tr_n = 0;
  always @(posedge sys_clk) begin
    ee_n <= eeprom_transfer_go ? DLY : (ee_n > 0 ? ee_n - 1 : 0);
    eeprom_done <= (ee_n == 1);
  end
  always @(posedge sys_clk) begin
    tr_n <= trim_transfer_go ? DLY : (tr_n > 0 ? tr_n - 1 : 0);
    trim_done <= (tr_n == 1);
  end
  // data only valid with done, garbage otherwise
  assign eeprom_read_data = (eeprom_done && eeprom_direction_select) ? RD : ~RD;
endmodule

// ==== sim/cal_regs_assertions.sv ====
// concurrent checks on the calibration register bank ports
`timescale 1ns/10ps
module cal_regs_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // host bus
  input wire logic [3:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  // transfer starts
  input wire logic eeprom_transfer_go,
  input wire logic trim_transfer_go,
  input wire logic reload_cal_go,
  input wire logic [6:0] cal_addr,
  // front end
  input wire logic input_polarity_select,
  input wire logic range_10v,
  input wire logic range_code_valid,
  input wire logic unipolar_offset_en,
  // results
  input wire logic adc_valid,
  input wire logic [15:0] adc_code,
  input wire logic result_valid,
  input wire logic signed [15:0] result_code
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ========================================
  // properties
  property p_ee_go;
    eeprom_transfer_go |-> $past(host_wr) && $past(host_addr) == cal_pkg::OFS_CAL_CTRL
      && $past(host_wdata[cal_pkg::CTRL_EE_GO]);
  endproperty
  a_ee_go: assert property (p_ee_go) else $error("eeprom start without control write");
  property p_ee_pulse;
    eeprom_transfer_go |=> !eeprom_transfer_go;
  endproperty
  a_ee_pulse: assert property (p_ee_pulse) else $error("eeprom start longer than one cycle");
  property p_trim_go;
    trim_transfer_go |-> $past(host_wr) && $past(host_addr) == cal_pkg::OFS_CAL_CTRL
      && $past(host_wdata[cal_pkg::CTRL_TRIM_GO]);
  endproperty
  a_trim_go: assert property (p_trim_go) else $error("trim start without control write");
  property p_reload;
    reload_cal_go |-> $past(host_wr && host_wdata[cal_pkg::CTRL_RUNCAL]);
  endproperty
  a_reload: assert property (p_reload) else $error("reload without control write");
  property p_rdata_hold;
    !$past(host_rd) |-> $stable(host_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  property p_addr_hold;
    !$past(host_wr) |-> $stable(cal_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved without write");
  property p_offset;
    unipolar_offset_en == input_polarity_select;
  endproperty
  a_offset: assert property (p_offset) else $error("offset enable differs from polarity");
  property p_invalid;
    !range_code_valid |-> input_polarity_select && !range_10v;
  endproperty
  a_invalid: assert property (p_invalid) else $error("code flagged invalid wrongly");
  property p_result;
    $past(adc_valid) |-> result_valid && result_code == $past(adc_code);
  endproperty
  a_result: assert property (p_result) else $error("result not one cycle after sample");
  property p_result_pulse;
    result_valid |-> $past(adc_valid);
  endproperty
  a_result_pulse: assert property (p_result_pulse) else $error("result without sample");
endmodule
bind cal_regs cal_regs_checker u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
  .host_rdata(host_rdata), .eeprom_transfer_go(eeprom_transfer_go),
  .trim_transfer_go(trim_transfer_go), .reload_cal_go(reload_cal_go), .cal_addr(cal_addr),
  .input_polarity_select(input_polarity_select), .range_10v(range_10v),
  .range_code_valid(range_code_valid), .unipolar_offset_en(unipolar_offset_en),
  .adc_valid(adc_valid), .adc_code(adc_code), .result_valid(result_valid),
  .result_code(result_code));

// ==== sim/tb_top.sv ====
// self-checking bench for the calibration register bank
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] REV = 8'h5C; // arbitrary value
  localparam logic [7:0] EE_RD = 8'h3C;
  logic sys_clk = 0, resetn = 0, host_wr = 0, host_rd = 0, adc_valid = 0, rd_d = 0;
  logic [3:0] host_addr = 4'h0;
  logic [7:0] host_wdata = 8'h00, host_rdata, ee_data, r, cal_data_o;
  logic [15:0] adc_code = 16'h0000;
  logic ee_go, ee_dir, ee_done, tr_go, tr_done, pol, r10, cval, res_v;
  logic cmux, reload, uoff;
  logic [6:0] cal_addr;
  logic [1:0] gain, scan;
  logic signed [15:0] res;
  logic [7:0] rq[$];
  logic [15:0] aq[$];
  int fails = 0, tests_run = 0, cyc = 0, reload_n = 0;
  int sp[16];
  initial forever #12.5 sys_clk = ~sys_clk;
  cal_regs #(.REVISION_CODE(REV)) u_cal_regs (.sys_clk(sys_clk), .resetn(resetn),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .eeprom_transfer_go(ee_go), .eeprom_direction_select(ee_dir),
    .eeprom_done(ee_done), .eeprom_read_data(ee_data), .trim_transfer_go(tr_go),
    .trim_done(tr_done), .cal_addr(cal_addr), .cal_data(cal_data_o), .reload_cal_go(reload),
    .cal_mux_enable(cmux), .input_polarity_select(pol), .range_10v(r10),
    .input_gain_select(gain), .range_code_valid(cval), .scan_interval(scan),
    .unipolar_offset_en(uoff), .adc_valid(adc_valid), .adc_code(adc_code),
    .result_valid(res_v), .result_code(res));
  cal_engine_model #(.DLY(6), .RD(EE_RD)) u_cal_engine_model (.sys_clk(sys_clk),
    .eeprom_transfer_go(ee_go), .eeprom_direction_select(ee_dir), .trim_transfer_go(tr_go),
    .eeprom_done(ee_done), .eeprom_read_data(ee_data), .trim_done(tr_done));
  // ========================================
  // helpers
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #2 host_addr = a;
    host_wdata = d;
    host_wr = 1;
    @(posedge sys_clk);
    #2 host_wr = 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge sys_clk);
    #2 host_addr = a;
    host_rd = 1;
    @(posedge sys_clk);
    #2 host_rd = 0;
  endtask
  // ========================================
  // output monitor
  always @(posedge sys_clk) rd_d <= host_rd;
  always @(negedge sys_clk) begin
    if (rd_d) chk("host_rdata", {8'h00, rq.pop_front()}, {8'h00, host_rdata});
    if (res_v === 1'b1) chk("result_code", aq.pop_front(), res);
    if (reload === 1'b1) reload_n++;
    cyc++;
    if (cyc > 3000) begin
      fails++;
      wrap_up();
    end
  end
  // ========================================
  // main sequence
  initial begin
    void'($urandom(32'hDFFD2B2D));
    repeat (6) @(posedge sys_clk);
    #2 resetn = 1;
    rd(4'h8, 8'h00);
    rd(4'hE, 8'h00);
    wr(4'h8, 8'h03);
    rd(4'hF, REV);
    wr(4'hE, 8'hC0);
    rd(4'hE, 8'h00);
    wr(4'hF, 8'hA5);
    wr(4'hE, 8'hC0);
    rd(4'hE, 8'h20);
    repeat (12) @(posedge sys_clk);
    rd(4'hE, 8'h00);
    rd(4'hC, EE_RD);
    chk("cal_data", {8'h00, EE_RD}, {8'h00, cal_data_o});
    r = 8'($urandom);
    wr(4'hC, r);
    wr(4'hE, 8'h80);
    rd(4'hE, 8'h20);
    repeat (12) @(posedge sys_clk);
    rd(4'hC, r);
    wr(4'h8, 8'h03);
    wr(4'hE, 8'hC0);
    rd(4'hE, 8'h00);
    wr(4'hE, 8'h38);
    rd(4'hE, 8'h58);
    chk("cal_mux_enable", 16'h0001, {15'h0000, cmux});
    repeat (12) @(posedge sys_clk);
    rd(4'hE, 8'h18);
    chk("reload_cal_go", 16'h0001, 16'(reload_n));
    r = 8'($urandom);
    wr(4'hD, r);
    chk("cal_addr", {9'h000, r[6:0]}, {9'h000, cal_addr});
    wr(4'h8, 8'h00);
    rd(4'hF, 8'h00);
    for (int c = 0; c < 16; c++) begin
      r = 8'($urandom);
      wr(4'hB, {2'b00, r[5:4], c[3:0]});
      chk("decode", {11'h000, c[3:2] != 2'b01, c[2], c[3], c[1:0]},
        {11'h000, cval, pol, r10, gain});
      chk("scan_interval", {14'h0000, r[5:4]}, {14'h0000, scan});
      chk("unipolar_offset_en", {15'h0000, c[2]}, {15'h0000, uoff});
      sp[c] = (r10 ? 10000 : 5000) >> gain;
      if (c >= 9 && c <= 11) chk("span", 16'(sp[c - 9]), 16'(sp[c]));
      rd(4'hB, {4'h0, c[3:0]});
    end
    r = 8'($urandom);
    // host skips codes 4 to 7
    if (r[3:2] == 2'b01) r[3] = 1'b1;
    wr(4'hB, {4'h0, r[3:0]});
    chk("range_code_valid", 16'h0001, {15'h0000, cval});
    repeat (20) begin
      @(posedge sys_clk);
      #2 adc_code = 16'($urandom);
      adc_valid = 1'($urandom);
      if (adc_valid) aq.push_back(adc_code);
    end
    @(posedge sys_clk);
    #2 adc_valid = 0;
    repeat (4) @(posedge sys_clk);
    chk("pending", 16'h0000, 16'(rq.size() + aq.size()));
    wrap_up();
  end
endmodule
